// ==== core/psic_pkg.sv ====
// Package: register map, field positions and carrier types for the PHY status interrupt block
package psic_pkg;

  // Register byte offsets (control and event offsets are printed word indices shifted left by two)
  localparam logic [7:0] OFF_STATUS_SUMMARY = 8'h10;
  localparam logic [7:0] OFF_INT_CONTROL    = 8'h11 << 2;
  localparam logic [7:0] OFF_EVENT_STATUS   = 8'h12 << 2;
  localparam logic [7:0] OFF_RAW_STATUS     = 8'h50;

  // Status summary fields
  localparam int SS_LINK_BIT   = 0;
  localparam int SS_SPEED_BIT  = 1;
  localparam int SS_DUPLEX_BIT = 2;
  localparam int SS_IRQ_BIT    = 7;

  // Interrupt control fields
  localparam int IC_OE_BIT     = 0;
  localparam int IC_GIE_BIT    = 1;
  localparam int IC_TEST_BIT   = 2;
  localparam int IC_WIDTH      = 3;
  localparam logic [2:0] IC_RESET = 3'h0;

  // Event status and enable layout
  localparam int NUM_EVENTS    = 7;
  localparam int EV_STAT_LSB   = 8;
  localparam int EV_EN_LSB     = 0;
  localparam logic [6:0] EV_RESET = 7'h00;

  // Event index order, low to high: rx-err half, false-carrier half, aneg, duplex, speed, link, energy
  localparam int EV_RXERR  = 0;
  localparam int EV_FCAR   = 1;
  localparam int EV_ANEG   = 2;
  localparam int EV_DUPLEX = 3;
  localparam int EV_SPEED  = 4;
  localparam int EV_LINK   = 5;
  localparam int EV_ENERGY = 6;

  // Live PHY state coming from the rest of the device
  typedef struct packed {
    logic energy;
    logic link;
    logic speed10;
    logic full_duplex;
    logic aneg_enabled;
    logic aneg_done;
    logic fcar_half;
    logic rxerr_half;
  } psic_phy_s;

endpackage

// ==== core/psic_event_latch.sv ====
// Sticky event bits with read-to-clear where a new event wins over the clear
`timescale 1ns/1ps
module psic_event_latch #(
  parameter int N = 7
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Events and clear
  input  wire logic [N-1:0] event_pulse,
  input  wire logic         clear_on_read,
  // Sticky state
  output logic      [N-1:0] pending_q
);

  //////////////////////////////////////////////////////////////////////////////
  // [RULE12] Latch since last read
  // [RULE15] Clear on read, set wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pending_q <= '0;
    else if (clear_on_read)
      pending_q <= event_pulse;
    else
      pending_q <= pending_q | event_pulse;
  end

  //////////////////////////////////////////////////////////////////////////////
  // [RULE15] Read clears unless same-cycle event
  clear_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    clear_on_read |=> pending_q == $past(event_pulse)) // RULE15
    else $error("pending bits not cleared by read");

  // [RULE12] Event is captured next cycle
  event_held_a: assert property (@(posedge pclk) disable iff (!presetn)
    |event_pulse |=> (pending_q & $past(event_pulse)) == $past(event_pulse)) // RULE12
    else $error("event not latched");

endmodule // psic_event_latch

// ==== core/psic_top.sv ====
// PHY status summary and interrupt control with APB register access
// Function
// [RULE1] Summary bit 2 shows full duplex as 1 and half duplex as 0.
// [RULE2] Duplex and speed only carry meaning with a valid link and finished or disabled negotiation.
// [RULE3] Summary bit 1 shows 10 Mb/s as 1 and 100 Mb/s as 0.
// [RULE4] Summary bit 0 mirrors the link bit and reading the summary never alters it.
// [RULE5] The mirrored link bit is 1 while a link is up at either speed, else 0.
// [RULE6] Interrupt control bits 15 to 3 read zero and ignore writes.
// [RULE7] The test bit forces an interrupt for as long as it stays set.
// [RULE8] The global enable lets event interrupts through, still gated per event.
// [RULE9] The output-enable bit makes the shared pin an interrupt output, else a power-down input.
// [RULE10] Sources are energy, link, speed, duplex, negotiation done and both counter half-full.
// [RULE11] Host software sets the per-event enables it wants.
// [RULE12] A status bit is set when its event occurred since the last event register read.
// [RULE13] An event interrupts only when its enable and the global controls allow it.
// [RULE14] Status bits set even with the interrupt disabled.
// [RULE15] Reading the event register clears the pending status bits.
// [RULE16] Summary bit 7 flags a pending interrupt and clears on event register read; the code sets it from any latched event, enabled or not.
// [RULE17] The pin is driven low only with output enable and a test or permitted pending event.
`timescale 1ns/1ps
module psic_top (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // PHY state from the device core
  input  wire psic_pkg::psic_phy_s phy_state,
  // Shared power-down / interrupt pin
  input  wire logic              powerdown_or_irq_pin_in,
  output logic                   powerdown_or_irq_pin_out,
  output logic                   powerdown_or_irq_pin_oe,
  // Power-down request taken from the pin
  output logic                   powerdown_req,
  // Level interrupt to the local processor
  output logic                   irq
);

  //////////////////////////////////////////////////////////////////////////////
  // PHY state capture (may come from other clock regions of the PHY)
  psic_pkg::psic_phy_s phy_meta_q;
  psic_pkg::psic_phy_s phy_q;
  psic_pkg::psic_phy_s phy_prev_q;
  logic                pin_meta_q;
  logic                pin_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phy_meta_q <= '0;
      phy_q      <= '0;
      phy_prev_q <= '0;
    end
    else
    begin
      phy_meta_q <= phy_state;
      phy_q      <= phy_meta_q;
      phy_prev_q <= phy_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta_q <= 1'b1;
      pin_q      <= 1'b1;
    end
    else
    begin
      pin_meta_q <= powerdown_or_irq_pin_in;
      pin_q      <= pin_meta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status qualification
  logic status_valid;
  // [RULE2] Valid only with link and settled negotiation
  assign status_valid = phy_q.link & (phy_q.aneg_done | ~phy_q.aneg_enabled);

  //////////////////////////////////////////////////////////////////////////////
  // Event detection
  logic [psic_pkg::NUM_EVENTS-1:0] ev_pulse;
  logic [psic_pkg::NUM_EVENTS-1:0] ev_pending;

  // [RULE10] All seven event sources
  always_comb
  begin
    ev_pulse                      = '0;
    ev_pulse[psic_pkg::EV_ENERGY] = phy_q.energy ^ phy_prev_q.energy;
    ev_pulse[psic_pkg::EV_LINK]   = phy_q.link ^ phy_prev_q.link;
    ev_pulse[psic_pkg::EV_SPEED]  = phy_q.speed10 ^ phy_prev_q.speed10;
    ev_pulse[psic_pkg::EV_DUPLEX] = phy_q.full_duplex ^ phy_prev_q.full_duplex;
    ev_pulse[psic_pkg::EV_ANEG]   = phy_q.aneg_done & ~phy_prev_q.aneg_done;
    ev_pulse[psic_pkg::EV_FCAR]   = phy_q.fcar_half & ~phy_prev_q.fcar_half;
    ev_pulse[psic_pkg::EV_RXERR]  = phy_q.rxerr_half & ~phy_prev_q.rxerr_half;
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB decode
  logic apb_access;
  logic wr_ctrl;
  logic wr_event;
  logic rd_event;
  logic addr_known;

  assign apb_access = psel & penable;
  assign addr_known = (paddr == psic_pkg::OFF_STATUS_SUMMARY) |
                      (paddr == psic_pkg::OFF_INT_CONTROL) |
                      (paddr == psic_pkg::OFF_EVENT_STATUS) |
                      (paddr == psic_pkg::OFF_RAW_STATUS);
  assign wr_ctrl    = apb_access & pwrite & pstrb[0] & (paddr == psic_pkg::OFF_INT_CONTROL);
  assign wr_event   = apb_access & pwrite & pstrb[0] & (paddr == psic_pkg::OFF_EVENT_STATUS);
  assign rd_event   = apb_access & ~pwrite & (paddr == psic_pkg::OFF_EVENT_STATUS);

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt control and event enables
  logic [psic_pkg::IC_WIDTH-1:0]   int_ctrl_q;
  logic [psic_pkg::NUM_EVENTS-1:0] ev_enable_q;

  // [RULE6] Only the low three bits are stored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_ctrl_q <= psic_pkg::IC_RESET;
    else if (wr_ctrl)
      int_ctrl_q <= pwdata[psic_pkg::IC_WIDTH-1:0];
  end

  // Enables sit in the low byte of the event register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ev_enable_q <= psic_pkg::EV_RESET;
    else if (wr_event)
      ev_enable_q <= pwdata[psic_pkg::EV_EN_LSB +: psic_pkg::NUM_EVENTS];
  end

  // Read data is snapshotted a cycle before the clear, so re-latch
  // anything that arrived after the snapshot instead of losing it
  logic [psic_pkg::NUM_EVENTS-1:0] ev_keep;
  assign ev_keep = {psic_pkg::NUM_EVENTS{rd_event}} & ev_pending &
                   ~prdata[psic_pkg::EV_STAT_LSB +: psic_pkg::NUM_EVENTS];

  // [RULE14] Status latches regardless of enables
  psic_event_latch #(
    .N (psic_pkg::NUM_EVENTS)
  ) u_latch (
    .pclk          (pclk),
    .presetn       (presetn),
    .event_pulse   (ev_pulse | ev_keep),
    .clear_on_read (rd_event),
    .pending_q     (ev_pending)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt generation
  logic test_on;
  logic gie_on;
  logic oe_on;
  logic event_irq;
  logic irq_any;

  assign test_on = int_ctrl_q[psic_pkg::IC_TEST_BIT];
  assign gie_on  = int_ctrl_q[psic_pkg::IC_GIE_BIT];
  assign oe_on   = int_ctrl_q[psic_pkg::IC_OE_BIT];
  // [RULE8] Global gate over per-event enables
  // [RULE13] Enable and global permit both needed
  assign event_irq = gie_on & |(ev_pending & ev_enable_q);
  // [RULE7] Test bit forces interrupt
  assign irq_any   = event_irq | test_on;

  // Pin and irq registered so every output leaves a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq                      <= 1'b0;
      powerdown_or_irq_pin_oe  <= 1'b0;
      powerdown_or_irq_pin_out <= 1'b1;
      powerdown_req            <= 1'b0;
    end
    else
    begin
      irq                      <= irq_any;
      // [RULE9] Pin direction from output enable
      powerdown_or_irq_pin_oe  <= oe_on;
      // [RULE17] Active-low drive when permitted
      powerdown_or_irq_pin_out <= ~(oe_on & irq_any);
      // Input mode: low level requests power-down
      powerdown_req            <= ~oe_on & ~pin_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read mux and APB response
  logic [31:0] rdata_d;

  always_comb
  begin
    rdata_d = '0;
    case (paddr)
      psic_pkg::OFF_STATUS_SUMMARY:
      begin
        // [RULE1] Duplex in bit 2
        rdata_d[psic_pkg::SS_DUPLEX_BIT] = phy_q.full_duplex;
        // [RULE3] Speed in bit 1
        rdata_d[psic_pkg::SS_SPEED_BIT]  = phy_q.speed10;
        // [RULE4] Mirror is never cleared by reads
        // [RULE5] Link up at either speed
        rdata_d[psic_pkg::SS_LINK_BIT]   = phy_q.link;
        // [RULE16] Pending flag from latched events
        rdata_d[psic_pkg::SS_IRQ_BIT]    = |ev_pending;
      end
      psic_pkg::OFF_INT_CONTROL:
        rdata_d[psic_pkg::IC_WIDTH-1:0] = int_ctrl_q;
      psic_pkg::OFF_EVENT_STATUS:
      begin
        rdata_d[psic_pkg::EV_STAT_LSB +: psic_pkg::NUM_EVENTS] = ev_pending;
        rdata_d[psic_pkg::EV_EN_LSB +: psic_pkg::NUM_EVENTS]   = ev_enable_q;
      end
      psic_pkg::OFF_RAW_STATUS:
      begin
        rdata_d[0] = status_valid;
        rdata_d[1] = phy_q.aneg_done;
        rdata_d[2] = phy_q.energy;
      end
      default:
        rdata_d = '0;
    endcase
  end

  // Zero wait states: pready is a flop asserted in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      prdata  <= (psel & ~penable & ~pwrite) ? rdata_d : prdata;
      pslverr <= psel & ~penable & ~addr_known;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  // [RULE7] Test bit raises irq next cycle
  test_forces_a: assert property (@(posedge pclk) disable iff (!presetn)
    test_on |=> irq) // RULE7
    else $error("test bit did not raise irq");

  // [RULE8] No event interrupt while global enable off
  gie_blocks_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!gie_on && !test_on) |=> !irq) // RULE8
    else $error("irq while globally disabled");

  // [RULE9] Pin direction follows output enable
  pin_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 powerdown_or_irq_pin_oe == $past(oe_on)) // RULE9
    else $error("pin direction mismatch");

  // [RULE17] Never driven low while released
  pin_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    !powerdown_or_irq_pin_oe |-> powerdown_or_irq_pin_out) // RULE17
    else $error("pin low while not driving");

  // [RULE6] Upper control bits read zero
  ctrl_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(pready) && $past(paddr == psic_pkg::OFF_INT_CONTROL && !pwrite)
    |-> prdata[31:psic_pkg::IC_WIDTH] == '0) // RULE6
    else $error("reserved control bits nonzero");

  // [RULE13] Masked events never interrupt
  mask_holds_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!test_on && (ev_pending & ev_enable_q) == '0) |=> !irq) // RULE13
    else $error("irq without enabled pending event");

  // [RULE14] Latch fills with enables cleared
  poll_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ev_pulse[psic_pkg::EV_LINK] && ev_enable_q == '0) |=> ev_pending[psic_pkg::EV_LINK]) // RULE14
    else $error("status not set while disabled");

  // [RULE4] Summary read leaves link latch alone
  link_kept_a: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_access && paddr == psic_pkg::OFF_STATUS_SUMMARY && !ev_pulse[psic_pkg::EV_LINK]
     && !rd_event) |=> ev_pending[psic_pkg::EV_LINK] == $past(ev_pending[psic_pkg::EV_LINK])) // RULE4
    else $error("summary read altered link state");

  // [RULE4] Summary read shows live link level
  link_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(pready) && $past(paddr == psic_pkg::OFF_STATUS_SUMMARY && !pwrite)
    |-> prdata[psic_pkg::SS_LINK_BIT] == $past(phy_q.link)) // RULE4
    else $error("summary link bit not live");

endmodule // psic_top

// ==== verification/psic_host_model.sv ====
// Host side of the shared power-down / interrupt pin
`timescale 1ns/1ps
module psic_host_model (
  // Device drive of the pin
  input  wire logic pin_out,
  input  wire logic pin_oe,
  // Host power-down request
  input  wire logic pd_req,
  // Resolved pin level and host view
  output logic      pin_level,
  output logic      irq_seen
);
  ////////////////////////////////////////////////////////////////////////////
  // host drives only an input pin
  // A released pin carries the host level !pd_req, never a stale value
  assign pin_level = pin_oe ? pin_out : !pd_req;
  assign irq_seen = pin_oe && !pin_level;
endmodule // psic_host_model

// ==== verification/tb_top.sv ====
// Register-level bench for the PHY status interrupt block
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] A_SS = psic_pkg::OFF_STATUS_SUMMARY;
  localparam logic [7:0] A_IC = psic_pkg::OFF_INT_CONTROL;
  localparam logic [7:0] A_EV = psic_pkg::OFF_EVENT_STATUS;
  logic                pclk;
  logic                presetn;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic                pd;
  logic                pready;
  logic                pslverr;
  logic                pin_out;
  logic                pin_oe;
  logic                pdreq;
  logic                irq;
  logic                pin_lvl;
  logic                irq_seen;
  logic                err;
  logic [7:0]          paddr;
  logic [3:0]          pstrb;
  logic [31:0]         pwdata;
  logic [31:0]         prdata;
  logic [31:0]         rdat;
  psic_pkg::psic_phy_s phy;
  int                  failures;
  int                  n_checks;
  int                  evbit [7] = '{0, 1, 2, 4, 5, 6, 7};

  psic_top i_psic_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phy_state(phy), .powerdown_or_irq_pin_in(pin_lvl),
    .powerdown_or_irq_pin_out(pin_out), .powerdown_or_irq_pin_oe(pin_oe),
    .powerdown_req(pdreq), .irq(irq));
  psic_host_model i_psic_host_model (.pin_out(pin_out), .pin_oe(pin_oe),
    .pd_req(pd), .pin_level(pin_lvl), .irq_seen(irq_seen));

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask

  // One APB transfer; idle edge after it so a next call never double-drives
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      failures++;
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdat);
  endtask

  task automatic flip(input int k);
    phy[k] <= ~phy[k];
    repeat (8) @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, pd} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    phy = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("oe_rst", 32'h0, pin_oe);
    rd(A_IC, 32'h0, "ic_rst");
    rd(A_EV, 32'h0, "ev_rst");
    rd(A_SS, 32'h0, "ss_rst");
    $display("test reset done");
    // Link up, 10 Mb/s, full duplex, negotiation off
    phy.link <= 1'b1;
    phy.speed10 <= 1'b1;
    phy.full_duplex <= 1'b1;
    repeat (8) @(posedge pclk);
    rd(A_SS, 32'h87, "ss_up");
    rd(A_SS, 32'h87, "ss_again");
    rd(A_EV, 32'h3800, "ev_chg");
    rd(A_SS, 32'h07, "ss_clr");
    rd(psic_pkg::OFF_RAW_STATUS, 32'h1, "raw_valid");
    phy.aneg_enabled <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(psic_pkg::OFF_RAW_STATUS, 32'h0, "raw_aneg");
    phy.aneg_enabled <= 1'b0;
    repeat (4) @(posedge pclk);
    $display("test summary done");
    apb(1'b1, A_IC, 32'hffffffff);
    rd(A_IC, 32'h7, "ic_mask");
    chk("pin_test", 32'h0, pin_out);
    chk("seen_test", 32'h1, irq_seen);
    apb(1'b1, A_IC, 32'h4);
    repeat (20) @(posedge pclk);
    chk("irq_test", 32'h1, irq);
    chk("oe_off", 32'h0, pin_oe);
    apb(1'b1, A_IC, 32'h0);
    @(posedge pclk);
    chk("irq_notest", 32'h0, irq);
    $display("test control done");
    apb(1'b1, A_IC, 32'h3);
    flip(7);
    chk("irq_noen", 32'h0, irq);
    chk("pin_noen", 32'h1, pin_out);
    rd(A_EV, 32'h4000, "ev_poll");
    apb(1'b1, A_EV, 32'h20);
    apb(1'b1, A_IC, 32'h1);
    flip(6);
    chk("irq_nogie", 32'h0, irq);
    apb(1'b1, A_IC, 32'h3);
    @(posedge pclk);
    chk("irq_gie", 32'h1, irq);
    chk("pin_gie", 32'h0, pin_out);
    rd(A_EV, 32'h2020, "ev_link");
    @(posedge pclk);
    chk("irq_clr", 32'h0, irq);
    rd(A_SS, 32'h06, "ss_down");
    $display("test gating done");
    apb(1'b1, A_EV, 32'h7f);
    for (int i = 0; i < 7; i++)
    begin
      flip(evbit[i]);
      chk("irq_src", 32'h1, irq);
      rd(A_EV, (32'h100 << i) | 32'h7f, "ev_src");
      if (i < 3)
        flip(evbit[i]);
    end
    $display("test sources done");
    apb(1'b0, 8'h20, 32'h0);
    chk("unmap_err", 32'h1, err);
    chk("unmap_data", 32'h0, rdat);
    apb(1'b1, A_SS, 32'hff);
    rd(A_SS, 32'h1, "ss_ro");
    apb(1'b1, A_IC, 32'h0);
    pd <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("pd_on", 32'h1, pdreq);
    apb(1'b1, A_IC, 32'h1);
    repeat (6) @(posedge pclk);
    chk("pd_out", 32'h0, pdreq);
    pd <= 1'b0;
    $display("test refuse and pin done");
    final_report;
  end

  // Run needs about 250 cycles; a hang is cut well beyond that
  initial
  begin
    repeat (6000) @(posedge pclk);
    failures++;
    final_report;
  end
endmodule // tb_top
